//--- efcp_pkg.sv
package efcp_pkg;
    // Channel word layout
    localparam int CW_FMT_LSB = 28;
    localparam int CW_RSV_LSB = 16;
    localparam int CW_CNT_LSB = 0;
    localparam logic [3:0] CW_FMT_IEEE8023 = 4'h0;
    localparam logic [11:0] CW_RSV_VALUE = 12'h000;
    localparam logic [15:0] CW_CNT_MAX = 16'hffff;
    localparam logic [3:0] CW_WORDS = 4'h2;

    // Frame identification word layout
    localparam int ID_MAC_ERR_BIT = 31;
    localparam int ID_TRN_ERR_BIT = 30;
    localparam int ID_CONTENT_LSB = 28;
    localparam int ID_SPEED_LSB = 24;
    localparam int ID_NET_LSB = 16;
    localparam int ID_PAY_ERR_BIT = 15;
    localparam int ID_LEN_ERR_BIT = 14;
    localparam int ID_LEN_W = 14;
    localparam logic [1:0] CONTENT_FULL_MAC = 2'h0;
    localparam logic [3:0] SPEED_AUTO = 4'h0;
    localparam logic [3:0] SPEED_10M = 4'h1;
    localparam logic [3:0] SPEED_100M = 4'h2;
    localparam logic [3:0] SPEED_1G = 4'h3;
    localparam logic [3:0] SPEED_10G = 4'h4;
    localparam logic [15:0] LEN_MIN = 16'h0040;
    localparam logic [15:0] LEN_MAX = 16'h05ee;
    localparam logic [3:0] HDR_WORDS = 4'h6;
    localparam logic [7:0] FILLER = 8'h00;

    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    localparam logic [7:0] REG_WPTR = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TFMT_LSB = 2;
    localparam int CTRL_ABS_BIT = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK_BITS = 32'h0000_004d;
    localparam int ST_FRAME_BIT = 0;
    localparam int ST_PKT_BIT = 1;
    localparam int ST_LENERR_BIT = 2;
    localparam int ST_W = 3;

    typedef enum logic [1:0] {
        EFCP_IDLE,
        EFCP_DATA,
        EFCP_HDR,
        EFCP_CW
    } efcp_state_e;
endpackage : efcp_pkg

//--- efcp_framer.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module efcp_framer #(
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic [63:0] abs_time,
    input wire logic frm_start,
    input wire logic [3:0] frm_speed,
    input wire logic [7:0] frm_network_identifier,
    output logic start_ready,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    input wire logic byte_mac_check_error,
    input wire logic byte_transmission_error,
    input wire logic byte_payload_check_error,
    output logic byte_ready,
    input wire logic pkt_close,
    output logic close_ready,
    output logic out_valid,
    output logic [ADDR_W-1:0] out_addr,
    output logic [15:0] out_word
);

    ////////////////////////////////////////////////////////////////////////////

    efcp_pkg::efcp_state_e st_reg;
    logic [31:0] ctrl_reg;
    logic [efcp_pkg::ST_W-1:0] status_reg;
    logic [efcp_pkg::ST_W-1:0] mask_reg;
    logic [efcp_pkg::ST_W-1:0] event_next;
    logic [47:0] rtc_reg;
    logic [63:0] ts_reg;
    logic ts_abs_reg;
    logic [15:0] len_reg;
    logic [15:0] count_reg;
    logic [ADDR_W-1:0] wptr_reg;
    logic [ADDR_W-1:0] base_reg;
    logic [3:0] idx_reg;
    logic [7:0] hold_reg;
    logic [3:0] speed_reg;
    logic [7:0] net_reg;
    logic mac_err_reg;
    logic trn_err_reg;
    logic pay_err_reg;
    logic start_take;
    logic close_take;
    logic byte_take;
    logic len_bad;
    logic [31:0] id_word;
    logic [31:0] cw_word;

    // Select one 16-bit half of a 32-bit word
    function automatic logic [15:0] half_sel(input logic [31:0] w, input logic hi);
        half_sel = hi ? w[31:16] : w[15:0];
    endfunction : half_sel

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes

    // Start beats close so a waiting frame is never starved by a close
    assign start_ready = (st_reg == efcp_pkg::EFCP_IDLE) && ctrl_reg[efcp_pkg::CTRL_EN_BIT]
        && (count_reg != efcp_pkg::CW_CNT_MAX);
    assign close_ready = (st_reg == efcp_pkg::EFCP_IDLE) && !frm_start;
    assign byte_ready = (st_reg == efcp_pkg::EFCP_DATA);
    assign start_take = frm_start && start_ready;
    assign close_take = pkt_close && close_ready;
    assign byte_take = byte_valid && byte_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly

    assign len_bad = (len_reg < efcp_pkg::LEN_MIN) || (len_reg > efcp_pkg::LEN_MAX);

    always_comb begin
        id_word = '0;
        id_word[efcp_pkg::ID_MAC_ERR_BIT] = mac_err_reg;
        id_word[efcp_pkg::ID_TRN_ERR_BIT] = trn_err_reg;
        id_word[efcp_pkg::ID_CONTENT_LSB +: 2] = efcp_pkg::CONTENT_FULL_MAC;
        id_word[efcp_pkg::ID_SPEED_LSB +: 4] = speed_reg;
        id_word[efcp_pkg::ID_NET_LSB +: 8] = net_reg;
        id_word[efcp_pkg::ID_PAY_ERR_BIT] = pay_err_reg;
        id_word[efcp_pkg::ID_LEN_ERR_BIT] = len_bad;
        id_word[efcp_pkg::ID_LEN_W-1:0] = len_reg[efcp_pkg::ID_LEN_W-1:0];
    end

    always_comb begin
        cw_word = '0;
        cw_word[efcp_pkg::CW_FMT_LSB +: 4] = efcp_pkg::CW_FMT_IEEE8023;
        cw_word[efcp_pkg::CW_RSV_LSB +: 12] = efcp_pkg::CW_RSV_VALUE;
        cw_word[efcp_pkg::CW_CNT_LSB +: 16] = count_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Relative time counter, free running

    always_ff @(posedge clock) begin
        if (srst) begin
            rtc_reg <= '0;
        end else begin
            rtc_reg <= rtc_reg + 48'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clock) begin
        if (srst) begin
            st_reg <= efcp_pkg::EFCP_IDLE;
            idx_reg <= '0;
        end else begin
            case (st_reg)
                efcp_pkg::EFCP_IDLE: begin
                    idx_reg <= '0;
                    if (start_take) begin
                        st_reg <= efcp_pkg::EFCP_DATA;
                    end else if (close_take) begin
                        st_reg <= efcp_pkg::EFCP_CW;
                    end
                end
                efcp_pkg::EFCP_DATA: begin
                    if (byte_take && byte_last) begin
                        st_reg <= efcp_pkg::EFCP_HDR;
                    end
                end
                efcp_pkg::EFCP_HDR: begin
                    idx_reg <= idx_reg + 4'h1;
                    if (idx_reg == efcp_pkg::HDR_WORDS - 4'h1) begin
                        st_reg <= efcp_pkg::EFCP_IDLE;
                    end
                end
                efcp_pkg::EFCP_CW: begin
                    idx_reg <= idx_reg + 4'h1;
                    if (idx_reg == efcp_pkg::CW_WORDS - 4'h1) begin
                        st_reg <= efcp_pkg::EFCP_IDLE;
                    end
                end
                default: begin
                    st_reg <= efcp_pkg::EFCP_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame bookkeeping

    // The header slot is reserved up front and filled once length and errors are known
    always_ff @(posedge clock) begin
        if (srst) begin
            wptr_reg <= ADDR_W'(efcp_pkg::CW_WORDS);
            base_reg <= '0;
            count_reg <= '0;
        end else if (start_take) begin
            base_reg <= wptr_reg;
            wptr_reg <= wptr_reg + ADDR_W'(efcp_pkg::HDR_WORDS);
        end else if (byte_take && (len_reg[0] || byte_last)) begin
            wptr_reg <= wptr_reg + ADDR_W'(1);
        end else if (st_reg == efcp_pkg::EFCP_HDR && idx_reg == efcp_pkg::HDR_WORDS - 4'h1) begin
            count_reg <= count_reg + 16'h1;
        end else if (st_reg == efcp_pkg::EFCP_CW && idx_reg == efcp_pkg::CW_WORDS - 4'h1) begin
            wptr_reg <= ADDR_W'(efcp_pkg::CW_WORDS);
            count_reg <= '0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            speed_reg <= efcp_pkg::SPEED_AUTO;
            net_reg <= '0;
        end else if (start_take) begin
            speed_reg <= frm_speed;
            net_reg <= frm_network_identifier;
        end
    end

    // Length saturates so a runaway frame cannot wrap back to a legal size
    always_ff @(posedge clock) begin
        if (srst) begin
            len_reg <= '0;
        end else if (start_take) begin
            len_reg <= '0;
        end else if (byte_take && len_reg != 16'hffff) begin
            len_reg <= len_reg + 16'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ts_reg <= '0;
            ts_abs_reg <= 1'b0;
        end else if (byte_take && len_reg == 16'h0) begin
            if (ctrl_reg[efcp_pkg::CTRL_ABS_BIT]) begin
                ts_reg <= abs_time;
            end else begin
                ts_reg <= {16'h0000, rtc_reg};
            end
            ts_abs_reg <= ctrl_reg[efcp_pkg::CTRL_ABS_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mac_err_reg <= 1'b0;
            trn_err_reg <= 1'b0;
            pay_err_reg <= 1'b0;
        end else if (byte_take && byte_last) begin
            mac_err_reg <= byte_mac_check_error;
            trn_err_reg <= byte_transmission_error;
            pay_err_reg <= byte_payload_check_error;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            hold_reg <= '0;
        end else if (byte_take && !len_reg[0]) begin
            hold_reg <= byte_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output word stream

    always_ff @(posedge clock) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_addr <= '0;
            out_word <= '0;
        end else begin
            out_valid <= 1'b0;
            if (byte_take && len_reg[0]) begin
                out_valid <= 1'b1;
                out_addr <= wptr_reg;
                out_word <= {byte_data, hold_reg};
            end else if (byte_take && byte_last) begin
                out_valid <= 1'b1;
                out_addr <= wptr_reg;
                out_word <= {efcp_pkg::FILLER, byte_data};
            end else if (st_reg == efcp_pkg::EFCP_HDR) begin
                out_valid <= 1'b1;
                out_addr <= base_reg + ADDR_W'(idx_reg);
                case (idx_reg)
                    4'h0: out_word <= ts_reg[15:0];
                    4'h1: out_word <= ts_reg[31:16];
                    4'h2: out_word <= ts_reg[47:32];
                    4'h3: out_word <= ts_reg[63:48];
                    4'h4: out_word <= half_sel(id_word, 1'b0);
                    default: out_word <= half_sel(id_word, 1'b1);
                endcase
            end else if (st_reg == efcp_pkg::EFCP_CW) begin
                out_valid <= 1'b1;
                out_addr <= ADDR_W'(idx_reg);
                out_word <= half_sel(cw_word, idx_reg[0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and interrupt

    always_comb begin
        event_next = '0;
        event_next[efcp_pkg::ST_FRAME_BIT] = (st_reg == efcp_pkg::EFCP_HDR)
            && (idx_reg == efcp_pkg::HDR_WORDS - 4'h1);
        event_next[efcp_pkg::ST_LENERR_BIT] = event_next[efcp_pkg::ST_FRAME_BIT] && len_bad;
        event_next[efcp_pkg::ST_PKT_BIT] = (st_reg == efcp_pkg::EFCP_CW)
            && (idx_reg == efcp_pkg::CW_WORDS - 4'h1);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg <= efcp_pkg::CTRL_RESET;
            mask_reg <= '0;
        end else if (reg_wr && reg_hit(reg_addr, efcp_pkg::REG_CTRL)) begin
            ctrl_reg <= reg_wdata & efcp_pkg::CTRL_MASK_BITS;
        end else if (reg_wr && reg_hit(reg_addr, efcp_pkg::REG_MASK)) begin
            mask_reg <= reg_wdata[efcp_pkg::ST_W-1:0];
        end
    end

    // A read clears the sticky bits, but an event in the same cycle survives
    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg <= '0;
        end else if (reg_rd && reg_hit(reg_addr, efcp_pkg::REG_STATUS)) begin
            status_reg <= event_next;
        end else begin
            status_reg <= status_reg | event_next;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    efcp_pkg::REG_CTRL: reg_rdata <= ctrl_reg;
                    efcp_pkg::REG_STATUS: reg_rdata <= 32'(status_reg);
                    efcp_pkg::REG_MASK: reg_rdata <= 32'(mask_reg);
                    efcp_pkg::REG_COUNT: reg_rdata <= {16'h0000, count_reg};
                    efcp_pkg::REG_WPTR: reg_rdata <= 32'(wptr_reg);
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_cw_first_addr: assert property (@(posedge clock) disable iff (srst)
        close_take |=> ##1 (out_valid && out_addr == '0) ##1 (out_addr == ADDR_W'(1)))
        else $error("channel word not at body start");

    a_cw_format_code: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_CW && idx_reg == 4'h1) |=> out_word[15:12] == 4'h0)
        else $error("channel word format code wrong");

    a_cw_reserved_zero: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_CW && idx_reg == 4'h1) |=> out_word[11:0] == 12'h000)
        else $error("channel word reserved bits set");

    a_cw_frame_count: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_CW && idx_reg == 4'h0) |=> out_word == $past(count_reg))
        else $error("channel word count wrong");

    a_hdr_slot_order: assert property (@(posedge clock) disable iff (srst)
        start_take |=> (base_reg == $past(wptr_reg)) && (wptr_reg == ADDR_W'($past(wptr_reg) + 6)))
        else $error("header slot not reserved");

    a_ts_high_zero: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_HDR && idx_reg == 4'h3 && !ts_abs_reg) |=> out_word == '0)
        else $error("relative time high bits not zero");

    a_mac_err_bit: assert property (@(posedge clock) disable iff (srst)
        (byte_take && byte_last) |=> ##6 out_word[15] == $past(byte_mac_check_error, 7))
        else $error("mac check error bit wrong");

    a_len_err_bit: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_HDR && idx_reg == 4'h4) |=>
        out_word[14] == ($past(len_reg) < 64 || $past(len_reg) > 1518))
        else $error("length error bit wrong");

    a_len_field: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_HDR && idx_reg == 4'h4) |=> out_word[13:0] == $past(len_reg[13:0]))
        else $error("length field wrong");

    a_filler_zero: assert property (@(posedge clock) disable iff (srst)
        (byte_take && byte_last && !len_reg[0]) |=> out_valid && out_word[15:8] == 8'h00)
        else $error("filler byte not zero");

    a_count_step: assert property (@(posedge clock) disable iff (srst)
        (st_reg == efcp_pkg::EFCP_HDR && idx_reg == 4'h5) |=> count_reg == $past(count_reg) + 16'h1)
        else $error("frame count not advanced");

endmodule : efcp_framer

//--- efcp_src_model.sv
`timescale 1ns/100ps
module efcp_src_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic start_ready,
    input wire logic byte_ready,
    output logic frm_start,
    output logic [3:0] frm_speed,
    output logic [7:0] frm_network_identifier,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic byte_last,
    output logic byte_mac_check_error,
    output logic byte_transmission_error,
    output logic byte_payload_check_error
);
    logic [47:0] rtc;

    // Relative time as the framer counts it: cleared by reset, one step per clock
    always @(posedge clock) begin
        rtc <= srst ? 48'h0 : rtc + 48'h1;
    end

    initial begin
        frm_start = 1'b0;
        frm_speed = 4'h0;
        frm_network_identifier = 8'h00;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        byte_last = 1'b0;
        {byte_mac_check_error, byte_transmission_error, byte_payload_check_error} = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ready is read at the falling edge; it cannot move before the next rising edge
    task automatic wait_ready(input bit which);
        bit taken;
        do begin
            @(negedge clock);
            taken = which ? byte_ready : start_ready;
            @(posedge clock);
        end while (!taken);
    endtask : wait_ready

    // Error lines carry the inverse except on the last byte, where they are sampled
    task automatic send(input int n, input logic [3:0] spd, input logic [7:0] net,
                        input logic [2:0] err, input logic [7:0] b0, input bit slow,
                        output logic [47:0] t0);
        int i;
        frm_start <= 1'b1;
        frm_speed <= spd;
        frm_network_identifier <= net;
        wait_ready(1'b0);
        frm_start <= 1'b0;
        frm_speed <= ~spd;
        frm_network_identifier <= ~net;
        for (i = 0; i < n; i++) begin
            byte_valid <= 1'b1;
            byte_data <= b0 + 8'(i);
            byte_last <= (i == n - 1);
            {byte_mac_check_error, byte_transmission_error,
             byte_payload_check_error} <= (i == n - 1) ? err : ~err;
            wait_ready(1'b1);
            if (i == 0) begin
                t0 = rtc;
            end
            if (slow) begin
                byte_valid <= 1'b0;
                byte_data <= ~(b0 + 8'(i));
                @(posedge clock);
            end
        end
        byte_valid <= 1'b0;
        byte_last <= 1'b0;
        byte_data <= ~(b0 + 8'(n - 1));
    endtask : send
endmodule : efcp_src_model

//--- efcp_framer_tb.sv
`timescale 1ns/100ps
module efcp_framer_tb;
    logic clock, srst, reg_wr, reg_rd, pkt_close, irq, start_ready, byte_ready;
    logic close_ready, out_valid, frm_start, byte_valid, byte_last, e_mac, e_trn, e_pay, rd_d;
    logic [7:0] reg_addr, frm_net, byte_data;
    logic [31:0] reg_wdata, reg_rdata, sa, sb;
    logic [63:0] abs_time;
    logic [3:0] frm_speed;
    logic [15:0] out_addr, out_word, lfsr, wptr;
    logic [31:0] rq[$], oq[$], mq[$];
    int fails, samples_checked, cycles, k;
    int lens[6] = '{1, 63, 64, 1518, 1519, 2};
    logic [2:0] errs[6] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h7, 3'h0};

    efcp_framer uut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .abs_time(abs_time), .frm_start(frm_start), .frm_speed(frm_speed),
        .frm_network_identifier(frm_net), .start_ready(start_ready),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last),
        .byte_mac_check_error(e_mac), .byte_transmission_error(e_trn),
        .byte_payload_check_error(e_pay), .byte_ready(byte_ready), .pkt_close(pkt_close),
        .close_ready(close_ready), .out_valid(out_valid), .out_addr(out_addr),
        .out_word(out_word));
    efcp_src_model src (.clock(clock), .srst(srst), .start_ready(start_ready),
        .byte_ready(byte_ready), .frm_start(frm_start), .frm_speed(frm_speed),
        .frm_network_identifier(frm_net),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last),
        .byte_mac_check_error(e_mac), .byte_transmission_error(e_trn),
        .byte_payload_check_error(e_pay));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Strobes stay up between bus tasks, so each signal is assigned once per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clock);
    endtask : rd

    task automatic tick(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic see(input logic seen, input logic exp);
        @(negedge clock);
        check({31'h0, seen}, {31'h0, exp});
        @(posedge clock);
    endtask : see

    task automatic expect_w(input logic [15:0] a, input logic [15:0] w, input logic [15:0] m);
        oq.push_back({a, w});
        mq.push_back({16'hffff, m});
    endtask : expect_w

    task automatic frame(input int n, input logic [3:0] spd, input logic [2:0] err,
                         input bit slow, input bit abs_on);
        logic [7:0] b0, net;
        logic [31:0] id;
        logic [63:0] ts;
        logic [47:0] t0;
        int j;
        lfsr = lfsr_step(lfsr);
        b0 = lfsr[7:0];
        net = lfsr[15:8];
        id = {err[2], err[1], 2'h0, spd, net, err[0], (n < 64 || n > 1518), 14'(n)};
        for (j = 0; j < (n + 1) / 2; j++)
            expect_w(wptr + 16'h6 + 16'(j),
                     {(2 * j + 1 < n) ? b0 + 8'(2 * j + 1) : 8'h00, b0 + 8'(2 * j)}, 16'hffff);
        // Header notes wait for the stamp, fixed only when the first byte is taken
        src.send(n, spd, net, err, b0, slow, t0);
        ts = abs_on ? abs_time : {16'h0000, t0};
        for (j = 0; j < 4; j++)
            expect_w(wptr + 16'(j), ts[16 * j +: 16], 16'hffff);
        expect_w(wptr + 16'h4, id[15:0], 16'hffff);
        expect_w(wptr + 16'h5, id[31:16], 16'hffff);
        wptr = wptr + 16'h6 + 16'((n + 1) / 2);
    endtask : frame

    task automatic close_pkt(input logic [15:0] cnt);
        bit taken;
        expect_w(16'h0, cnt, 16'hffff);
        expect_w(16'h1, 16'h0000, 16'hffff);
        pkt_close <= 1'b1;
        do begin
            @(negedge clock);
            taken = close_ready;
            @(posedge clock);
        end while (!taken);
        pkt_close <= 1'b0;
        wptr = 16'h2;
    endtask : close_pkt

    task automatic drain();
        for (int i = 0; i < 40 && oq.size() > 0; i++)
            @(posedge clock);
    endtask : drain

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock) begin
        if (rd_d)
            check(reg_rdata, rq.pop_front());
        rd_d = reg_rd;
        if (out_valid && oq.size() == 0)
            check({out_addr, out_word}, 32'hffff_ffff);
        else if (out_valid) begin
            sa = oq.pop_front();
            sb = mq.pop_front();
            check({out_addr, out_word} & sb, sa & sb);
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        srst = 1'b1;
        {reg_wr, reg_rd, pkt_close, rd_d} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        abs_time = 64'h0;
        lfsr = 16'h0041;
        wptr = 16'h2;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        tick(1);
        rd(efcp_pkg::REG_CTRL, efcp_pkg::CTRL_RESET);
        rd(efcp_pkg::REG_STATUS, 32'h0);
        rd(efcp_pkg::REG_MASK, 32'h0);
        wr(efcp_pkg::REG_COUNT, 32'hffff);
        rd(efcp_pkg::REG_COUNT, 32'h0);
        rd(efcp_pkg::REG_WPTR, 32'h2);
        rd(8'h14, 32'h0);
        tick(1);
        $display("test registers done");
        // Every speed code, each error flag alone, both length limits, odd and even
        for (k = 0; k < 6; k++) begin
            if (k == 5) begin
                drain();
                abs_time <= {lfsr, ~lfsr, 16'h0f0f, lfsr};
                wr(efcp_pkg::REG_CTRL, 32'h0000_0045);
                rd(efcp_pkg::REG_CTRL, 32'h0000_0045);
                tick(1);
            end
            frame(lens[k], 4'(k % 5), errs[k], k[0], k == 5);
        end
        drain();
        rd(efcp_pkg::REG_COUNT, 32'h6);
        rd(efcp_pkg::REG_WPTR, {16'h0, wptr});
        tick(1);
        $display("test frames done");
        see(irq, 1'b0);
        wr(efcp_pkg::REG_MASK, 32'h1);
        tick(1);
        see(irq, 1'b1);
        rd(efcp_pkg::REG_STATUS, 32'h5);
        tick(1);
        see(irq, 1'b0);
        $display("test interrupt done");
        close_pkt(16'h6);
        drain();
        rd(efcp_pkg::REG_STATUS, 32'h2);
        rd(efcp_pkg::REG_COUNT, 32'h0);
        rd(efcp_pkg::REG_WPTR, 32'h2);
        tick(1);
        see(irq, 1'b0);
        close_pkt(16'h0);
        drain();
        $display("test close done");
        wr(efcp_pkg::REG_CTRL, 32'h0);
        tick(1);
        see(start_ready, 1'b0);
        wr(efcp_pkg::REG_CTRL, 32'h1);
        tick(1);
        see(start_ready, 1'b1);
        frame(3, 4'h4, 3'h0, 1'b0, 1'b0);
        drain();
        close_pkt(16'h1);
        drain();
        tick(2);
        $display("test enable done");
        check(32'(oq.size() + rq.size()), 32'h0);
        print_verdict();
    end
endmodule : efcp_framer_tb
